// ### hw/i2c_port_consts.svh
`ifndef I2C_PORT_CONSTS_SVH
`define I2C_PORT_CONSTS_SVH
// Overview of operation
// [RULE1] Slave acknowledges every byte it receives
// [RULE2] Master gives a ninth clock per byte
// [RULE3] Acknowledger holds data low through clock high
// [RULE4] Master nacks last read; slave releases data
// [RULE5] All bytes go most significant bit first
// [RULE6] Master alone makes clocks, START and STOP
// [RULE7] STOP or repeated START ends a transfer
// [RULE8] First byte is address plus direction; 0 writes
// [RULE9] Direction 1 makes the slave transmit
// [RULE10] Acknowledge address only on own match
// [RULE11] First written byte loads register pointer
// [RULE12] Data bytes written, acknowledged, pointer incremented
// [RULE13] Master ends writes with STOP
// [RULE14] Read starts at current pointer register
// [RULE15] Pointer survives between transfers
// [RULE16] Slave keeps sending until master nacks
// [RULE17] Straight wiring answers 30h, swapped 31h
// [RULE18] Master reads identification register twice after startup
// [RULE19] Works at 100kHz and 400kHz clock
// [RULE20] Pointer increments after each transmitted byte

// ----------------------------------------
// Bus addresses and register file
// ----------------------------------------
`define ADDR_STRAIGHT 7'h30
`define ADDR_SWAPPED  7'h31
`define DIR_WRITE     1'b0
`define DIR_READ      1'b1
`define ID_REG_ADDR   8'h00
`define PTR_RESET     8'h00
`define REG_COUNT     16
`define REG_IDX_W     4

// ----------------------------------------
// Timing
// ----------------------------------------
`define CORE_HZ     20000000
`define SCL_HZ      400000
`define SCL_QTR_CYC ((`CORE_HZ + 4 * `SCL_HZ - 1) / (4 * `SCL_HZ))
`define ID_READS    2
`endif

// ### hw/i2c_port_pkg.sv
`include "i2c_port_consts.svh"

package i2c_port_pkg;

  // ----------------------------------------
  // Slave end, link and core clock domains
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE     = 3'b000,
    S_ADDR     = 3'b001,
    S_ADDR_ACK = 3'b010,
    S_RX       = 3'b011,
    S_RX_ACK   = 3'b100,
    S_TX       = 3'b101,
    S_TX_ACK   = 3'b110,
    S_WAIT     = 3'b111
  } slave_state_t;

  typedef struct packed {
    slave_state_t                  st;
    logic [1:0]                    pins_q;
    logic                          det;
    logic                          swap;
    logic [3:0]                    cnt;
    logic [7:0]                    sh;
    logic [7:0]                    ptr;
    logic                          first;
    logic                          rw;
    logic                          mack;
    logic                          oe;
    logic                          a_oe;
    logic                          b_oe;
    logic                          wr_tgl;
    logic [7:0]                    wr_addr;
    logic [7:0]                    wr_data;
    logic [`REG_COUNT-1:0][7:0]    regs;
  } slave_link_t;

  typedef struct packed {
    logic       tgl_q;
    logic       stb;
    logic [7:0] addr;
    logic [7:0] data;
    logic       known;
    logic       swap;
  } slave_core_t;

  // ----------------------------------------
  // Master end
  // ----------------------------------------
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_START = 2'b01,
    H_BYTE  = 2'b10,
    H_STOP  = 2'b11
  } host_state_t;

  typedef enum logic [2:0] {
    G_ADDR_W = 3'b000,
    G_PTR    = 3'b001,
    G_WDATA  = 3'b010,
    G_ADDR_R = 3'b011,
    G_RDATA  = 3'b100
  } host_stage_t;

  typedef struct packed {
    host_state_t st;
    host_stage_t stg;
    logic [1:0]  ph;
    logic [7:0]  qcnt;
    logic [3:0]  bcnt;
    logic [7:0]  sh;
    logic        scl_oe;
    logic        sda_oe;
    logic [1:0]  inits;
    logic        ready;
    logic        rd;
    logic        setp;
    logic [6:0]  addr;
    logic [7:0]  ptr;
    logic [7:0]  wdata;
    logic [3:0]  cnt;
    logic        ack_n;
    logic        rd_stb;
    logic [7:0]  rd_data;
    logic        done;
    logic        nack;
  } host_t;

endpackage : i2c_port_pkg

// ### hw/i2c_link_if.sv
`timescale 1ns/100ps

interface i2c_link_if #(
  parameter bit SWAPPED = 1'b0
);
  logic link_clk;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_a_o;
  logic dev_a_oe;
  logic dev_b_o;
  logic dev_b_oe;
  logic scl;
  logic sda;
  logic pin_a;
  logic pin_b;
  logic a_low;
  logic b_low;

  // ----------------------------------------
  // Wired-AND bus with pull-ups
  // ----------------------------------------
  assign a_low = dev_a_oe && !dev_a_o;
  assign b_low = dev_b_oe && !dev_b_o;
  assign scl   = !(host_scl_oe && !host_scl_o) && !(SWAPPED ? b_low : a_low);
  assign sda   = !(host_sda_oe && !host_sda_o) && !(SWAPPED ? a_low : b_low);
  assign pin_a = SWAPPED ? sda : scl;
  assign pin_b = SWAPPED ? scl : sda;

  modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input sda);
  modport dev  (input link_clk, pin_a, pin_b, output dev_a_o, dev_a_oe, dev_b_o, dev_b_oe);
endinterface : i2c_link_if

// ### hw/sync2.sv
`timescale 1ns/100ps

// Two-stage synchroniser; only the second stage is visible
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // ----------------------------------------
  // Stages
  // ----------------------------------------
  always_ff @(posedge clk) begin
    meta_q <= d;
    q      <= meta_q;
  end
endmodule : sync2

// ### hw/i2c_reg_slave.sv
`timescale 1ns/100ps
`include "i2c_port_consts.svh"

module i2c_reg_slave
  import i2c_port_pkg::*;
#(
  parameter logic [7:0] ID_VALUE = 8'hA5  // Arbitrary identification value
) (
  i2c_link_if.dev    link,
  input  wire logic  core_clk,
  input  wire logic  rst_n,
  output logic       reg_wr_stb,
  output logic [7:0] reg_wr_addr,
  output logic [7:0] reg_wr_data,
  output logic       wiring_known,
  output logic       wiring_swapped
);

  // ----------------------------------------
  // Link clock domain signals
  // ----------------------------------------
  slave_link_t s;
  slave_link_t n;
  logic [1:0]  pins;
  logic        lrst_n;
  logic        scl_now;
  logic        sda_now;
  logic        scl_was;
  logic        sda_was;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic [6:0]  my_addr;

  // ----------------------------------------
  // Core clock domain signals
  // ----------------------------------------
  slave_core_t c;
  slave_core_t cn;
  logic [2:0]  csy;

  // Register read; the identification byte is fixed and never stored
  function automatic logic [7:0] reg_read(input slave_link_t st);
    logic [7:0] v;
    v = 8'h00;
    if (st.ptr == `ID_REG_ADDR) begin
      v = ID_VALUE;
    end else if (st.ptr < 8'(`REG_COUNT)) begin
      v = st.regs[st.ptr[`REG_IDX_W-1:0]];
    end
    return v;
  endfunction : reg_read

  // Load the next byte to send and step the pointer past it
  function automatic slave_link_t tx_load(input slave_link_t st);
    slave_link_t r;
    r     = st;
    r.sh  = reg_read(st);            // RULE14
    r.oe  = ~r.sh[7];                // RULE5
    r.cnt = 4'h0;
    r.ptr = st.ptr + 8'h01;          // RULE20
    r.st  = S_TX;
    return r;
  endfunction : tx_load

  // Pins and reset pass two flops; link_clk oversamples SCL
  sync2 #(.W(2)) u_pin_sync (
    .clk (link.link_clk),
    .d   ({link.pin_b, link.pin_a}),
    .q   (pins)
  );  // RULE19

  sync2 #(.W(1)) u_rst_sync (
    .clk (link.link_clk),
    .d   (rst_n),
    .q   (lrst_n)
  );

  // Bus view follows the detected wiring
  assign scl_now  = s.swap ? pins[1] : pins[0];
  assign sda_now  = s.swap ? pins[0] : pins[1];
  assign scl_was  = s.swap ? s.pins_q[1] : s.pins_q[0];
  assign sda_was  = s.swap ? s.pins_q[0] : s.pins_q[1];
  assign scl_rise = scl_now & ~scl_was;
  assign scl_fall = ~scl_now & scl_was;
  assign start_c  = scl_now & scl_was & sda_was & ~sda_now;
  assign stop_c   = scl_now & scl_was & ~sda_was & sda_now;
  assign my_addr  = s.swap ? `ADDR_SWAPPED : `ADDR_STRAIGHT;  // RULE17

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  always_comb begin
    n        = s;
    n.pins_q = pins;
    if (!s.det) begin
      // First fall from idle is a START; the pin that fell carries data.
      // Assumes the bus is idle when reset is released.
      if (s.pins_q == 2'b11 && (pins == 2'b01 || pins == 2'b10)) begin  // RULE17 RULE18
        n.det  = 1'b1;
        n.swap = pins[1];
        n.st   = S_ADDR;
        n.cnt  = 4'h0;
      end
    end else if (start_c) begin
      // Repeated START restarts address decode, pointer kept
      n.st  = S_ADDR;  // RULE7 RULE15
      n.cnt = 4'h0;
      n.oe  = 1'b0;
    end else if (stop_c) begin
      n.st = S_IDLE;  // RULE7
      n.oe = 1'b0;
    end else if (scl_rise) begin
      if (s.st == S_ADDR || s.st == S_RX) begin
        n.sh  = {s.sh[6:0], sda_now};  // RULE5
        n.cnt = s.cnt + 4'h1;
      end
      if (s.st == S_TX_ACK) begin
        n.mack = ~sda_now;
      end
    end else if (scl_fall) begin
      unique case (s.st)
        S_ADDR: begin
          if (s.cnt == 4'h8) begin
            if (s.sh[7:1] == my_addr) begin  // RULE8 RULE10
              n.oe = 1'b1;                   // RULE1 RULE3
              n.rw = s.sh[0];
              n.st = S_ADDR_ACK;
            end else begin
              n.st = S_WAIT;
            end
          end
        end
        S_ADDR_ACK: begin
          if (s.rw == `DIR_READ) begin
            n = tx_load(n);                  // RULE9 RULE14
          end else begin
            n.oe    = 1'b0;
            n.cnt   = 4'h0;
            n.first = 1'b1;
            n.st    = S_RX;
          end
        end
        S_RX: begin
          if (s.cnt == 4'h8) begin
            if (s.first) begin
              n.ptr   = s.sh;                // RULE11
              n.first = 1'b0;
            end else begin
              if (s.ptr != `ID_REG_ADDR && s.ptr < 8'(`REG_COUNT)) begin
                n.regs[s.ptr[`REG_IDX_W-1:0]] = s.sh;  // RULE12
              end
              n.wr_tgl  = ~s.wr_tgl;
              n.wr_addr = s.ptr;
              n.wr_data = s.sh;
              n.ptr     = s.ptr + 8'h01;     // RULE12
            end
            n.oe = 1'b1;                     // RULE1 RULE3
            n.st = S_RX_ACK;
          end
        end
        S_RX_ACK: begin
          n.oe  = 1'b0;
          n.cnt = 4'h0;
          n.st  = S_RX;
        end
        S_TX: begin
          if (s.cnt == 4'h7) begin
            n.oe = 1'b0;                     // Let the master answer
            n.st = S_TX_ACK;
          end else begin
            n.sh  = {s.sh[6:0], 1'b0};
            n.oe  = ~s.sh[6];                // RULE5
            n.cnt = s.cnt + 4'h1;
          end
        end
        S_TX_ACK: begin
          if (s.mack) begin
            n = tx_load(n);                  // RULE16
          end else begin
            n.oe = 1'b0;                     // RULE4
            n.st = S_WAIT;
          end
        end
        S_IDLE, S_WAIT: begin
          // Idle or foreign transfer: only START or STOP moves on
        end
      endcase
    end
    // Only the detected data pin is ever driven, never the clock
    n.a_oe = n.oe & n.swap;
    n.b_oe = n.oe & ~n.swap;
  end

  always_ff @(posedge link.link_clk) begin
    if (!lrst_n) begin
      s        <= '0;
      s.pins_q <= 2'b11;
      s.ptr    <= `PTR_RESET;
    end else begin
      s <= n;
    end
  end

  assign link.dev_a_o  = 1'b0;
  assign link.dev_b_o  = 1'b0;
  assign link.dev_a_oe = s.a_oe;
  assign link.dev_b_oe = s.b_oe;

  // ----------------------------------------
  // Crossing to core clock
  // ----------------------------------------
  // Write data is held until the next write, many SCL periods away,
  // so only the toggle needs synchronising
  sync2 #(.W(3)) u_core_sync (
    .clk (core_clk),
    .d   ({s.wr_tgl, s.swap, s.det}),
    .q   (csy)
  );

  always_comb begin
    cn       = c;
    cn.tgl_q = csy[2];
    cn.stb   = csy[2] ^ c.tgl_q;
    if (csy[2] ^ c.tgl_q) begin
      cn.addr = s.wr_addr;
      cn.data = s.wr_data;
    end
    cn.swap  = csy[1];
    cn.known = csy[0];
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      c <= '0;
    end else begin
      c <= cn;
    end
  end

  assign reg_wr_stb     = c.stb;
  assign reg_wr_addr    = c.addr;
  assign reg_wr_data    = c.data;
  assign wiring_known   = c.known;
  assign wiring_swapped = c.swap;
endmodule : i2c_reg_slave

// ### hw/i2c_host_master.sv
`timescale 1ns/100ps
`include "i2c_port_consts.svh"

module i2c_host_master
  import i2c_port_pkg::*;
#(
  parameter logic [6:0] INIT_ADDR = `ADDR_STRAIGHT
) (
  i2c_link_if.host   link,
  input  wire logic  core_clk,
  input  wire logic  rst_n,
  input  wire logic  cmd_valid,
  output logic       cmd_ready,
  input  wire logic  cmd_read,
  input  wire logic  cmd_set_ptr,
  input  wire logic [6:0] cmd_addr,
  input  wire logic [7:0] cmd_ptr,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic [3:0] cmd_count,
  output logic       rd_valid,
  output logic [7:0] rd_data,
  output logic       xfer_done,
  output logic       xfer_nack
);

  host_t s;
  host_t n;
  logic  sda_in;
  logic  qt;

  // Byte sent in each stage; read data bytes leave the line released
  function automatic logic [7:0] tx_byte(input host_t h);
    logic [7:0] b;
    b = 8'hFF;
    unique case (h.stg)
      G_ADDR_W: b = {h.addr, `DIR_WRITE};
      G_ADDR_R: b = {h.addr, `DIR_READ};
      G_PTR:    b = h.ptr;
      G_WDATA:  b = h.wdata;
      default:  b = 8'hFF;
    endcase
    return b;
  endfunction : tx_byte

  sync2 #(.W(1)) u_sda_sync (
    .clk (core_clk),
    .d   (link.sda),
    .q   (sda_in)
  );

  // Quarter-period tick of SCL
  assign qt = (s.qcnt == 8'(`SCL_QTR_CYC - 1));  // RULE19

  // ----------------------------------------
  // Transfer sequencer
  // ----------------------------------------
  always_comb begin
    n        = s;
    n.rd_stb = 1'b0;
    n.done   = 1'b0;
    n.qcnt   = qt ? 8'h00 : s.qcnt + 8'h01;
    if (qt) begin
      n.ph = s.ph + 2'h1;
    end
    unique case (s.st)
      H_IDLE: begin
        n.ph    = 2'h0;
        n.qcnt  = 8'h00;
        n.ready = 1'b0;
        if (s.inits != 2'(`ID_READS)) begin
          // Identification read so the slave settles its address
          n.inits = s.inits + 2'h1;  // RULE18
          n.rd    = 1'b1;
          n.setp  = 1'b1;
          n.addr  = INIT_ADDR;
          n.ptr   = `ID_REG_ADDR;
          n.cnt   = 4'h1;
          n.stg   = G_ADDR_W;
          n.nack  = 1'b0;
          n.st    = H_START;
        end else if (cmd_valid && s.ready) begin
          n.rd    = cmd_read;
          n.setp  = cmd_set_ptr;
          n.addr  = cmd_addr;
          n.ptr   = cmd_ptr;
          n.wdata = cmd_wdata;
          n.cnt   = (cmd_read && cmd_count == 4'h0) ? 4'h1 : cmd_count;
          n.stg   = (cmd_set_ptr || !cmd_read) ? G_ADDR_W : G_ADDR_R;
          n.nack  = 1'b0;
          n.st    = H_START;
        end else begin
          n.ready = 1'b1;
        end
      end
      H_START: begin
        // Also serves as repeated START, entered with SCL low
        if (qt) begin
          unique case (s.ph)
            2'h0: n.sda_oe = 1'b0;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b1;  // RULE6 RULE7
            2'h3: begin
              n.scl_oe = 1'b1;
              n.bcnt   = 4'h0;
              n.sh     = tx_byte(s);
              n.st     = H_BYTE;
            end
          endcase
        end
      end
      H_BYTE: begin
        if (qt) begin
          unique case (s.ph)
            2'h0: begin
              if (s.bcnt == 4'h8) begin
                n.sda_oe = (s.stg == G_RDATA) && (s.cnt != 4'h1);  // RULE3 RULE4
              end else begin
                n.sda_oe = (s.stg != G_RDATA) && ~s.sh[7];         // RULE5
              end
            end
            2'h1: n.scl_oe = 1'b0;  // RULE2
            2'h2: begin
              if (s.bcnt == 4'h8) begin
                n.ack_n = sda_in;
              end else begin
                n.sh = {s.sh[6:0], sda_in};
              end
            end
            2'h3: begin
              n.scl_oe = 1'b1;
              n.bcnt   = s.bcnt + 4'h1;
              if (s.bcnt == 4'h8) begin
                n.bcnt = 4'h0;
                if (s.stg == G_RDATA) begin
                  n.rd_stb  = 1'b1;
                  n.rd_data = s.sh;
                  n.cnt     = s.cnt - 4'h1;
                  if (s.cnt == 4'h1) begin
                    n.st = H_STOP;
                  end
                end else if (s.ack_n) begin
                  n.nack = 1'b1;
                  n.st   = H_STOP;
                end else begin
                  unique case (s.stg)
                    G_ADDR_W: n.stg = s.setp ? G_PTR : G_WDATA;
                    G_ADDR_R: n.stg = G_RDATA;
                    G_PTR: begin
                      n.stg = s.rd ? G_ADDR_R : G_WDATA;
                      if (s.rd) begin
                        n.st = H_START;  // RULE7
                      end
                    end
                    G_WDATA: n.cnt = s.cnt - 4'h1;
                    default: begin
                    end
                  endcase
                  if (n.stg == G_WDATA && n.cnt == 4'h0) begin
                    n.st = H_STOP;  // RULE13
                  end
                end
                n.sh = tx_byte(n);
              end
            end
          endcase
        end
      end
      H_STOP: begin
        if (qt) begin
          unique case (s.ph)
            2'h0: n.sda_oe = 1'b1;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b0;  // RULE6 RULE13
            2'h3: begin
              n.done = 1'b1;
              n.st   = H_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign link.host_scl_o  = 1'b0;
  assign link.host_sda_o  = 1'b0;
  assign link.host_scl_oe = s.scl_oe;
  assign link.host_sda_oe = s.sda_oe;
  assign cmd_ready        = s.ready;
  assign rd_valid         = s.rd_stb;
  assign rd_data          = s.rd_data;
  assign xfer_done        = s.done;
  assign xfer_nack        = s.nack;
endmodule : i2c_host_master

// ### tb/i2c_link_props.sv
`timescale 1ns/100ps

module i2c_link_props #(
  parameter logic [6:0] ADDR = 7'h30
) (
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_a_oe,
  input wire logic dev_b_oe
);
  logic       scl_q, sda_q, first_q, rw_q, hit_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic       rise, start;

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Bus tracker
  // ----------------------------------------
  // Lines are sampled raw; the master moves them on the core clock, far slower than this one, and the slave on this one
  assign rise  = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;

  // Bit count since START, address byte and direction
  always_ff @(posedge link_clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (!rst_n) begin
      first_q <= 1'b0;
      hit_q   <= 1'b0;
      rw_q    <= 1'b0;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
    end else if (start) begin
      first_q <= 1'b1;
      cnt_q   <= 4'h0;
    end else if (rise && cnt_q == 4'h8) begin
      cnt_q   <= 4'h0;
      first_q <= 1'b0;
      if (first_q) begin
        rw_q  <= sh_q[0];
        hit_q <= sh_q[7:1] == ADDR;
      end
    end else if (rise) begin
      cnt_q <= cnt_q + 4'h1;
      sh_q  <= {sh_q[6:0], sda};
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_clock_untouched: assert property (!dev_a_oe) else $error("slave drove clock pin");
  a_addr_ack_match: assert property (rise && cnt_q == 4'h8 && first_q |-> sda == (sh_q[7:1] != ADDR))
    else $error("address acknowledge wrong");
  a_write_ack_low: assert property (rise && cnt_q == 4'h8 && !first_q && !rw_q && hit_q |-> !sda)
    else $error("written byte not acknowledged");
  a_stable_clock_high: assert property (scl && scl_q |-> $stable(dev_b_oe))
    else $error("slave data moved while clock high");
  a_drive_after_fall: assert property ($changed(dev_b_oe) |-> !scl &&
    ($past(scl, 2) || $past(scl, 3) || $past(scl, 4) || $past(scl, 5))) else $error("slave data moved late");
  a_master_slot_free: assert property (rise && cnt_q == 4'h8 && !first_q && rw_q && hit_q |-> !dev_b_oe)
    else $error("slave held data in master acknowledge slot");
  a_nack_silence: assert property (rise && cnt_q == 4'h8 && !first_q && rw_q && hit_q && sda
    |=> !dev_b_oe [*8]) else $error("slave drove data after not-acknowledge");
  a_deaf_on_miss: assert property (!first_q && !hit_q |-> !dev_b_oe) else $error("unaddressed slave drove data");
endmodule : i2c_link_props

// ### tb/tb.sv
`timescale 1ns/100ps
`include "i2c_port_consts.svh"

module tb;
  localparam logic [7:0] ID_VAL = 8'h5C;  // Arbitrary identification value
  logic       core_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
  logic       cmd_valid = 1'b0, cmd_read = 1'b0, cmd_set_ptr = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  logic [7:0] cmd_ptr = 8'h00, cmd_wdata = 8'h00;
  logic [3:0] cmd_count = 4'h0;
  logic       cmd_ready, rd_valid, xfer_done, xfer_nack, reg_wr_stb, wiring_known, wiring_swapped;
  logic       rd_valid_b, known_b, swapped_b;
  logic [7:0] rd_data, reg_wr_addr, reg_wr_data, rd_data_b, ptr;
  logic [7:0] mdl [16];
  logic [7:0] rq [$];
  logic [15:0] wq [$];
  int         n_mismatch = 0, n_checks = 0, n_id_b = 0;

  // ----------------------------------------
  // Clocks and the two wirings
  // ----------------------------------------
  always #25 core_clk = ~core_clk;
  // Odd offset keeps the link clock out of step with the core clock
  initial begin
    #2.7;
    forever #6 link_clk = ~link_clk;
  end

  i2c_link_if #(.SWAPPED(1'b0)) link_a ();
  i2c_link_if #(.SWAPPED(1'b1)) link_b ();
  assign link_a.link_clk = link_clk;
  assign link_b.link_clk = link_clk;

  i2c_host_master i_i2c_host_master (.link(link_a), .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_set_ptr(cmd_set_ptr), .cmd_addr(cmd_addr), .cmd_ptr(cmd_ptr),
    .cmd_wdata(cmd_wdata), .cmd_count(cmd_count), .rd_valid(rd_valid), .rd_data(rd_data), .xfer_done(xfer_done),
    .xfer_nack(xfer_nack));
  i2c_reg_slave #(.ID_VALUE(ID_VAL)) i_i2c_reg_slave (.link(link_a), .core_clk(core_clk), .rst_n(rst_n),
    .reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .wiring_known(wiring_known),
    .wiring_swapped(wiring_swapped));
  // Crossed pair only runs its startup reads; commands stay with the first host
  i2c_host_master #(.INIT_ADDR(`ADDR_SWAPPED)) i_i2c_host_master_b (.link(link_b), .core_clk(core_clk),
    .rst_n(rst_n), .cmd_valid(1'b0), .cmd_ready(), .cmd_read(cmd_read), .cmd_set_ptr(cmd_set_ptr),
    .cmd_addr(cmd_addr), .cmd_ptr(cmd_ptr), .cmd_wdata(cmd_wdata), .cmd_count(cmd_count), .rd_valid(rd_valid_b),
    .rd_data(rd_data_b), .xfer_done(), .xfer_nack());
  i2c_reg_slave #(.ID_VALUE(ID_VAL)) i_i2c_reg_slave_b (.link(link_b), .core_clk(core_clk), .rst_n(rst_n),
    .reg_wr_stb(), .reg_wr_addr(), .reg_wr_data(), .wiring_known(known_b), .wiring_swapped(swapped_b));
  i2c_link_props #(.ADDR(`ADDR_STRAIGHT)) i_i2c_link_props (.link_clk(link_clk), .rst_n(rst_n),
    .scl(link_a.scl), .sda(link_a.sda), .dev_a_oe(link_a.dev_a_oe), .dev_b_oe(link_a.dev_b_oe));

  // ----------------------------------------
  // Collectors, compare and end of run
  // ----------------------------------------
  // Falling edge keeps the strobes clear of the edge that launches them
  always @(negedge core_clk) begin
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (reg_wr_stb === 1'b1) wq.push_back({reg_wr_addr, reg_wr_data});
    if (rd_valid_b === 1'b1 && rd_data_b === ID_VAL) n_id_b++;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  // Register 00h reads the id, past the file reads zero
  function automatic logic [7:0] exp_rd(input logic [7:0] p);
    return (p == 8'h00) ? ID_VAL : (p < 8'h10) ? mdl[p[3:0]] : 8'h00;
  endfunction : exp_rd

  // One host command, then compare against the register model
  task automatic xfer(input logic rd, input logic sp, input logic [6:0] a, input logic [7:0] p,
                      input logic [7:0] wd, input logic [3:0] n);
    int  k;
    logic hit;
    hit = a == `ADDR_STRAIGHT;
    rq.delete();
    wq.delete();
    @(posedge core_clk) #1;
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_set_ptr = sp;
    cmd_addr = a;
    cmd_ptr = p;
    cmd_wdata = wd;
    cmd_count = n;
    for (k = 0; k < 30000 && cmd_ready !== 1'b1; k++) @(posedge core_clk) #1;
    @(posedge core_clk) #1;
    cmd_valid = 1'b0;
    for (k = 0; k < 20000 && xfer_done !== 1'b1; k++) @(posedge core_clk) #1;
    check("done", 16'(xfer_done), 16'h1);
    check("nack", 16'(xfer_nack), 16'(!hit));
    repeat (8) @(posedge core_clk);
    if (rd && n == 4'h0) n = 4'h1;
    check("read count", 16'(rq.size()), (hit && rd) ? 16'(n) : 16'h0);
    check("write count", 16'(wq.size()), (hit && !rd) ? 16'(n) : 16'h0);
    if (hit) begin
      if (sp) ptr = p;
      for (k = 0; k < n; k++) begin
        if (rd) check("read data", 16'(rq[k]), 16'(exp_rd(ptr)));
        else check("write", wq[k], {ptr, wd});
        if (!rd && ptr > 8'h00 && ptr < 8'h10) mdl[ptr[3:0]] = wd;
        ptr++;
      end
    end
  endtask : xfer

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h477208CC));
    foreach (mdl[i]) mdl[i] = 8'h00;
    repeat (16) @(posedge core_clk);
    #1 rst_n = 1'b1;
    for (int k = 0; k < 30000 && cmd_ready !== 1'b1; k++) @(posedge core_clk) #1;
    check("ready", 16'(cmd_ready), 16'h1);
    repeat (200) @(posedge core_clk);
    check("startup reads", 16'(rq.size()), 16'h2);
    check("id first", 16'(rq[0]), 16'(ID_VAL));
    check("id second", 16'(rq[1]), 16'(ID_VAL));
    check("wiring", {wiring_known, wiring_swapped, known_b, swapped_b}, 16'hB);
    check("crossed id reads", 16'(n_id_b), 16'h2);
    ptr = 8'h01;
    repeat (4) xfer(0, 1, `ADDR_STRAIGHT, 8'($urandom_range(1, 12)), 8'($urandom), 4'($urandom_range(1, 3)));
    // Pointer only, then reads that rely on the stored pointer
    xfer(0, 1, `ADDR_STRAIGHT, 8'h03, 8'h00, 4'h0);
    xfer(1, 0, `ADDR_STRAIGHT, 8'h00, 8'h00, 4'h4);
    xfer(1, 0, `ADDR_STRAIGHT, 8'h00, 8'h00, 4'h0);
    // Foreign addresses must be ignored
    xfer(0, 1, 7'h32, 8'h09, 8'h77, 4'h2);
    xfer(1, 0, `ADDR_SWAPPED, 8'h00, 8'h00, 4'h1);
    // Edge of the file and the read-only id
    xfer(0, 1, `ADDR_STRAIGHT, 8'h0F, 8'hC3, 4'h2);
    xfer(0, 1, `ADDR_STRAIGHT, 8'h00, 8'h3C, 4'h1);
    xfer(1, 1, `ADDR_STRAIGHT, 8'h0F, 8'h00, 4'h3);
    repeat (3) xfer(1, 1, `ADDR_STRAIGHT, 8'($urandom_range(0, 15)), 8'h00, 4'($urandom_range(1, 4)));
    xfer(1, 1, `ADDR_STRAIGHT, 8'h00, 8'h00, 4'hF);
    close_out();
  end

  // Hang guard, well past the longest expected run
  initial begin
    repeat (95000) @(posedge core_clk);
    n_mismatch++;
    close_out();
  end
endmodule : tb
